// ==== testbench.sv ====
// Self-checking bench for the config lock register bank.
// Assumes vcl_host drives commands and vcl_bank_chk is bound.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import vcl_pkg::*;
  logic clk = 0, rstn = 0, sr = 0, qim = 0, cs_n = 1, wp = 1, l3 = 1;
  logic [7:0] nvc = 8'h2E, d, cfg;
  logic [2:0] bpv;
  logic wpi, go, perr, l2d, l3d;
  vcl_stat_t s1nv;
  vcl_cmd_t cmd;
  vcl_rsp_t rsp;
  logic [7:0] q[$];
  int errors = 0, compares = 0, cyc = 0, seed = 65411, i;
  always #2.5 clk = ~clk;
  vcl_host vcl_host_i (.clk, .cmd);
  vcl_bank vcl_bank_i (.clk, .rstn, .cmd, .soft_reset(sr), .nv_config1_in(nvc),
    .nv_status1_in(4'h0), .quad_instruction_mode(qim), .cs_n, .wp_pin(wp),
    .lane3_or_hw_reset_pin(l3), .rsp, .config1_volatile(cfg), .config1_nonvolatile(),
    .status1_nonvolatile(s1nv), .status1_volatile_bp(bpv), .wp_internal(wpi),
    .lane2_is_data(l2d), .lane3_is_data(l3d), .otp_prog_go(go), .program_error(perr));
  task automatic chk(input logic [7:0] s, e, input string n);
    compares++;
    if (s !== e) begin
      errors++;
      $display("mismatch %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic rd(input logic [7:0] e, c = 8'h35, input logic [23:0] a = 24'h0);
    q.push_back(e);
    vcl_host_i.send(c, a, 8'h0, 8'h0);
  endtask
  task automatic results;
    if (errors == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(negedge clk) if (rsp.valid === 1'b1) chk(rsp.data, q.pop_front(), "rsp");
  always @(posedge clk) if (++cyc == 3000) begin
    errors++;
    results;
  end
  initial begin
    repeat (8) @(negedge clk);
    rstn = 1;
    repeat (2) @(negedge clk);
    rd(8'h2E);
    for (i = 0; i < 4; i++) begin
      d = 8'($random(seed));
      vcl_host_i.send(8'h01, 24'h0, d & 8'h7F, {d[7:1], 1'b0});
      rd({6'h0B, d[1], 1'b0});
      {wp, cs_n} = d[3:2];
      @(negedge clk);
      chk(8'(wpi), 8'(d[1] | d[3]), "wp");
      chk(8'(l2d), 8'(d[1]), "lane2");
      chk(8'(l3d), 8'(d[1] & ~d[2]), "lane3");
    end
    cs_n = 1;
    vcl_host_i.send(8'h42, 24'h10, 8'h0, 8'h0);
    chk(8'(go), 8'h01, "go");
    vcl_host_i.send(8'h01, 24'h0, 8'h1C, 8'h02);
    chk(8'(bpv), 8'h07, "bp");
    vcl_host_i.send(8'h01, 24'h0, 8'h1C, 8'h03);
    rd(8'h2F);
    vcl_host_i.send(8'h01, 24'h0, 8'h00, 8'h00);
    chk(8'(bpv), 8'h07, "bp");
    chk(8'(perr), 8'h00, "perr");
    rd(8'h2D);
    vcl_host_i.send(8'h71, 24'h000000, 8'h9C, 8'h00);
    chk(8'(s1nv), 8'h08, "status nv");
    rd(8'h80, 8'h65, 24'h000000);
    rd(8'h9C, 8'h65, 24'h800000);
    rd(8'h2D, 8'h65, 24'h800002);
    d = 8'($random(seed));
    vcl_host_i.send(8'h42, {14'h0, d[1:0], d}, 8'h0, 8'h0);
    chk(8'(perr), 8'h01, "perr");
    sr = 1;
    @(negedge clk);
    sr = 0;
    @(negedge clk);
    chk(8'(cfg[0]), 8'h01, "lock");
    vcl_host_i.send(8'h01, 24'h0, 8'h1C, 8'h02);
    qim = 1;
    vcl_host_i.send(8'h71, 24'h800002, 8'h00, 8'h00);
    rd(8'h2F);
    wp = 0;
    repeat (2) @(negedge clk);
    chk(8'(wpi), 8'h01, "wp");
    qim = 0;
    l3 = 0;
    @(negedge clk);
    l3 = 1;
    @(negedge clk);
    chk(8'(cfg[0]), 8'h00, "lock");
    chk(8'(cfg[1]), 8'h01, "quad");
    chk(8'(perr), 8'h00, "perr");
    chk(8'(q.size()), 8'h00, "pending");
    results;
  end
endmodule
`default_nettype wire

// ==== vcl_bank.sv ====
// Volatile configuration register 1 with lock, quad width control and mirrors.
// Assumes one clock, commands as one-cycle requests, and an outside array
// that stores the non-volatile images this block exports.
`timescale 1ns/1ps
`default_nettype none
`include "vcl_map.svh"

module vcl_bank (
  input wire logic clk,
  input wire logic rstn,
  input wire vcl_pkg::vcl_cmd_t cmd,
  input wire logic soft_reset,
  input wire logic [7:0] nv_config1_in,
  input wire vcl_pkg::vcl_stat_t nv_status1_in,
  input wire logic quad_instruction_mode,
  input wire logic cs_n,
  input wire logic wp_pin,
  input wire logic lane3_or_hw_reset_pin,
  output vcl_pkg::vcl_rsp_t rsp,
  output logic [7:0] config1_volatile,
  output logic [7:0] config1_nonvolatile,
  output vcl_pkg::vcl_stat_t status1_nonvolatile,
  output logic [2:0] status1_volatile_bp,
  output logic wp_internal,
  output logic lane2_is_data,
  output logic lane3_is_data,
  output logic otp_prog_go,
  output logic program_error
);
  import vcl_pkg::*;

  localparam logic [7:0] stat1_rst_val = `VCL_STAT1_RST;

  // Registered state
  logic loaded_ff;
  logic lock_ff;
  logic quad_ff;
  logic [7:0] cfg1_nv_ff;
  vcl_stat_t stat1_nv_ff;
  logic [2:0] bp_v_ff;
  logic [2:0] mirror_ff;
  vcl_rsp_t rsp_ff;
  logic wp_int_ff;
  logic lane2_ff;
  logic lane3_ff;
  logic otp_go_ff;
  logic p_err_ff;

  // Command decode
  logic hw_reset;
  logic wr_regs;
  logic wr_any;
  logic wr_cfg_v;
  logic wr_cfg_nv;
  logic wr_stat_v;
  logic wr_stat_nv;
  logic [7:0] cfg_byte;
  logic [7:0] stat_byte;
  logic nxt_quad_req;
  logic quad_clear_blocked;
  logic in_otp;
  logic otp_req;
  logic rd_hit;
  logic [7:0] rd_data;

  // Lane 3 acts as active-low hardware reset while deselected in quad width
  assign hw_reset = quad_ff & cs_n & ~lane3_or_hw_reset_pin;

  assign wr_regs = cmd.valid & (cmd.code == `VCL_CMD_WRITE_REGS);
  assign wr_any = cmd.valid & (cmd.code == `VCL_CMD_WRITE_ANY);

  // Write decode: which images a command touches
  always_comb begin
    wr_cfg_v = 1'b0;
    wr_cfg_nv = 1'b0;
    wr_stat_v = 1'b0;
    wr_stat_nv = 1'b0;
    if (wr_regs) begin
      wr_cfg_v = cmd.two_bytes;
      wr_cfg_nv = cmd.two_bytes;
      wr_stat_v = 1'b1;
      // With protect select set, only the volatile protect bits are written
      wr_stat_nv = ~cfg1_nv_ff[`VCL_BIT_SELECT];
    end else if (wr_any && cmd.addr == `VCL_AR_CONFIG1_V) begin
      wr_cfg_v = 1'b1;
    end else if (wr_any && cmd.addr == `VCL_AR_CONFIG1_NV) begin
      wr_cfg_nv = 1'b1;
    end else if (wr_any && cmd.addr == `VCL_AR_STATUS1_V) begin
      wr_stat_v = 1'b1;
    end else if (wr_any && cmd.addr == `VCL_AR_STATUS1_NV) begin
      wr_stat_nv = 1'b1;
    end
  end

  assign cfg_byte = wr_regs ? cmd.data1 : cmd.data0;
  assign stat_byte = cmd.data0;
  assign nxt_quad_req = cfg_byte[`VCL_BIT_QUAD];
  assign quad_clear_blocked = quad_instruction_mode & ~nxt_quad_req;
  assign in_otp = (cmd.addr >= `VCL_OTP_FIRST) && (cmd.addr <= `VCL_OTP_LAST);
  assign otp_req = cmd.valid & (cmd.code == `VCL_CMD_OTP_PROG) & in_otp;

  // Power-on image load happens once, on the first edge after release
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      loaded_ff <= 1'b0;
    end else begin
      loaded_ff <= 1'b1;
    end
  end

  // Lock bit: set by writes, cleared only by power-on or hardware reset
  // A write of 0 to the lock is not a clear, so only the set is decoded
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lock_ff <= 1'b0;
    end else if (!loaded_ff) begin
      lock_ff <= nv_config1_in[`VCL_BIT_LOCK];
    end else if (hw_reset) begin
      lock_ff <= cfg1_nv_ff[`VCL_BIT_LOCK];
    end else if (wr_cfg_v && cfg_byte[`VCL_BIT_LOCK]) begin
      lock_ff <= 1'b1;
    end
  end

  // Quad width bit; soft reset reloads it but leaves the lock alone
  // Quad-instruction mode blocks a clear of either quad copy
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      quad_ff <= 1'b0;
    end else if (!loaded_ff) begin
      quad_ff <= nv_config1_in[`VCL_BIT_QUAD];
    end else if (hw_reset || soft_reset) begin
      quad_ff <= cfg1_nv_ff[`VCL_BIT_QUAD];
    end else if ((wr_cfg_v || wr_cfg_nv) && !quad_clear_blocked) begin
      quad_ff <= nxt_quad_req;
    end
  end

  // Non-volatile config image: one-time bits only go 0 to 1, and not when locked
  // The lock-default bit is never written by commands
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfg1_nv_ff <= `VCL_CFG1_RST;
    end else if (!loaded_ff) begin
      cfg1_nv_ff <= nv_config1_in & (`VCL_OTP_MASK | 8'h03);
    end else if (wr_cfg_nv) begin
      if (!lock_ff) begin
        cfg1_nv_ff <= cfg1_nv_ff | (cfg_byte & `VCL_OTP_MASK);
      end
      if (!quad_clear_blocked) begin
        cfg1_nv_ff[`VCL_BIT_QUAD] <= nxt_quad_req;
      end
    end
  end

  // Non-volatile status image: block-protect frozen by the lock, write-disable not
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stat1_nv_ff <= '{srwd: stat1_rst_val[`VCL_BIT_SRWD],
                       bp: stat1_rst_val[`VCL_BP_HI:`VCL_BP_LO]};
    end else if (!loaded_ff) begin
      stat1_nv_ff <= nv_status1_in;
    end else if (wr_stat_nv) begin
      stat1_nv_ff.srwd <= stat_byte[`VCL_BIT_SRWD];
      if (!lock_ff) begin
        stat1_nv_ff.bp <= stat_byte[`VCL_BP_HI:`VCL_BP_LO];
      end
    end
  end

  // Volatile block-protect bits follow the image at reset, writes when unlocked
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bp_v_ff <= stat1_rst_val[`VCL_BP_HI:`VCL_BP_LO];
    end else if (!loaded_ff) begin
      bp_v_ff <= nv_status1_in.bp;
    end else if (hw_reset || soft_reset) begin
      bp_v_ff <= stat1_nv_ff.bp;
    end else if (wr_stat_v && !lock_ff) begin
      bp_v_ff <= stat_byte[`VCL_BP_HI:`VCL_BP_LO];
    end
  end

  // Read-only shadows track the one-time bits every cycle
  // Mirrors lag the image by one cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mirror_ff <= 3'h0;
    end else begin
      mirror_ff <= {cfg1_nv_ff[`VCL_BIT_ORIGIN], cfg1_nv_ff[`VCL_BIT_SELECT],
                    cfg1_nv_ff[`VCL_BIT_PARAM]};
    end
  end

  // Read data select for read-config and read-any
  always_comb begin
    rd_hit = 1'b0;
    rd_data = 8'h00;
    if (cmd.valid && cmd.code == `VCL_CMD_READ_CFG) begin
      rd_hit = 1'b1;
      rd_data = config1_volatile;
    end else if (cmd.valid && cmd.code == `VCL_CMD_READ_ANY) begin
      rd_hit = 1'b1;
      if (cmd.addr == `VCL_AR_CONFIG1_V) begin
        rd_data = config1_volatile;
      end else if (cmd.addr == `VCL_AR_CONFIG1_NV) begin
        rd_data = cfg1_nv_ff;
      end else if (cmd.addr == `VCL_AR_STATUS1_NV) begin
        rd_data = {stat1_nv_ff.srwd, 2'h0, stat1_nv_ff.bp, 2'h0};
      end else if (cmd.addr == `VCL_AR_STATUS1_V) begin
        rd_data = {stat1_nv_ff.srwd, 2'h0, bp_v_ff, 2'h0};
      end
    end
  end

  // Register reads answer one cycle after the command
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rsp_ff <= '0;
    end else begin
      rsp_ff.valid <= rd_hit;
      rsp_ff.data <= rd_data;
    end
  end

  // Quad width: write-protect ignored and seen as inactive high
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wp_int_ff <= 1'b1;
    end else begin
      wp_int_ff <= quad_ff ? 1'b1 : wp_pin;
    end
  end

  // Lane 2 carries data whenever quad width is on
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lane2_ff <= 1'b0;
    end else begin
      lane2_ff <= quad_ff;
    end
  end

  // Lane 3 is data only while selected; deselected in quad width it is the reset input
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lane3_ff <= 1'b0;
    end else begin
      lane3_ff <= quad_ff & ~cs_n;
    end
  end

  // One-time area program starts only while unlocked
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      otp_go_ff <= 1'b0;
    end else begin
      otp_go_ff <= otp_req & ~lock_ff & loaded_ff & ~hw_reset;
    end
  end

  // Program error is sticky; a refused program wins over a hardware reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      p_err_ff <= 1'b0;
    end else if (otp_req && lock_ff) begin
      p_err_ff <= 1'b1;
    end else if (!loaded_ff || hw_reset) begin
      p_err_ff <= 1'b0;
    end
  end

  // Reserved bits 7, 6 and 4 read as zero
  assign config1_volatile = {2'h0, mirror_ff[2], 1'b0,
                             mirror_ff[1:0], quad_ff, lock_ff};
  assign config1_nonvolatile = cfg1_nv_ff;
  assign status1_nonvolatile = stat1_nv_ff;
  assign status1_volatile_bp = bp_v_ff;
  assign rsp = rsp_ff;
  assign wp_internal = wp_int_ff;
  assign lane2_is_data = lane2_ff;
  assign lane3_is_data = lane3_ff;
  assign otp_prog_go = otp_go_ff;
  assign program_error = p_err_ff;

endmodule
`default_nettype wire

// ==== vcl_bank_chk.sv ====
// Port checker for the config lock register bank.
// Assumes the bank's single clock and async active-low reset.
`timescale 1ns/1ps
`default_nettype none
module vcl_bank_chk (
  input wire logic clk,
  input wire logic rstn,
  input wire vcl_pkg::vcl_cmd_t cmd,
  input wire logic soft_reset,
  input wire logic quad_instruction_mode,
  input wire logic cs_n,
  input wire logic lane3_or_hw_reset_pin,
  input wire vcl_pkg::vcl_rsp_t rsp,
  input wire logic [7:0] config1_volatile,
  input wire logic [7:0] config1_nonvolatile,
  input wire logic [2:0] status1_volatile_bp,
  input wire logic wp_internal,
  input wire logic otp_prog_go,
  input wire logic program_error
);
  import vcl_pkg::*;
  logic lk, qd, hw, rs, wr, otp;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  assign lk = config1_volatile[0];
  assign qd = config1_volatile[1];
  // Hardware reset is only seen in quad width
  assign hw = cs_n && !lane3_or_hw_reset_pin && qd;
  assign rs = hw || soft_reset;
  assign wr = cmd.valid && cmd.code == 8'h01 && cmd.two_bytes && !rs;
  assign otp = cmd.valid && cmd.code == 8'h42 && cmd.addr < 24'h000400;
  property p_rd; cmd.valid && cmd.code == 8'h35 && !rs
    |=> rsp.valid && rsp.data == $past(config1_volatile); endproperty
  property p_mir; (config1_volatile & 8'h2C) == ($past(config1_nonvolatile) & 8'h2C); endproperty
  property p_wp; qd |=> wp_internal; endproperty
  property p_qpi; quad_instruction_mode && qd && !rs |=> config1_volatile[1]; endproperty
  property p_wrr; wr && !quad_instruction_mode |=> config1_volatile[1] == $past(cmd.data1[1])
    && config1_nonvolatile[1] == $past(cmd.data1[1]); endproperty
  property p_bp; lk && !rs |=> $stable(status1_volatile_bp); endproperty
  property p_lk; lk && !hw |=> lk; endproperty
  property p_set; wr && cmd.data1[0] |=> lk; endproperty
  property p_otp; otp && lk |=> program_error && !otp_prog_go; endproperty
  property p_go; otp && !lk && !hw |=> otp_prog_go; endproperty
  a_rd: assert property (p_rd) else $error("read data wrong");
  a_mir: assert property (p_mir) else $error("mirror bits wrong");
  a_wp: assert property (p_wp) else $error("write protect active");
  a_qpi: assert property (p_qpi) else $error("quad cleared");
  a_wrr: assert property (p_wrr) else $error("quad copies wrong");
  a_bp: assert property (p_bp) else $error("locked protect changed");
  a_lk: assert property (p_lk) else $error("lock cleared");
  a_set: assert property (p_set) else $error("lock not set");
  a_otp: assert property (p_otp) else $error("locked program passed");
  a_go: assert property (p_go) else $error("program not started");
  c_set: cover property (p_set);
  c_otp: cover property (otp && lk);
  c_hw: cover property (hw);
endmodule
bind vcl_bank vcl_bank_chk vcl_bank_chk_i (.clk, .rstn, .cmd, .soft_reset,
  .quad_instruction_mode, .cs_n, .lane3_or_hw_reset_pin, .rsp, .config1_volatile,
  .config1_nonvolatile, .status1_volatile_bp, .wp_internal, .otp_prog_go, .program_error);
`default_nettype wire

// ==== vcl_host.sv ====
// Host model issuing finished register commands as one-cycle requests.
// Assumes the bench calls send from one process.
`timescale 1ns/1ps
`default_nettype none
module vcl_host (
  input wire logic clk,
  output var vcl_pkg::vcl_cmd_t cmd
);
  import vcl_pkg::*;
  initial cmd = '0;
  task automatic send(input logic [7:0] c, input logic [23:0] a, input logic [7:0] d0, d1);
    @(negedge clk);
    cmd <= '{1'b1, c, a, d0, d1, 1'b1};
    @(negedge clk);
    cmd <= '0;
  endtask
endmodule
`default_nettype wire

// ==== vcl_map.svh ====
// Constants for the volatile configuration / lock register bank.
// Assumes command opcodes arrive already decoded from the serial link.
`ifndef VCL_MAP_SVH
`define VCL_MAP_SVH
`define VCL_CMD_READ_CFG 8'h35
`define VCL_CMD_WRITE_REGS 8'h01
`define VCL_CMD_READ_ANY 8'h65
`define VCL_CMD_WRITE_ANY 8'h71
`define VCL_CMD_OTP_PROG 8'h42
`define VCL_AR_STATUS1_NV 24'h000000
`define VCL_AR_CONFIG1_NV 24'h000002
`define VCL_AR_STATUS1_V 24'h800000
`define VCL_AR_CONFIG1_V 24'h800002
`define VCL_OTP_FIRST 24'h000000
`define VCL_OTP_LAST 24'h0003FF
`define VCL_BIT_ORIGIN 5
`define VCL_BIT_SELECT 3
`define VCL_BIT_PARAM 2
`define VCL_BIT_QUAD 1
`define VCL_BIT_LOCK 0
`define VCL_BIT_SRWD 7
`define VCL_BP_HI 4
`define VCL_BP_LO 2
`define VCL_OTP_MASK 8'h2C
`define VCL_CFG1_RST 8'h00
`define VCL_STAT1_RST 8'h00
`endif

// ==== vcl_pkg.sv ====
// Types shared by the configuration lock register bank.
// Assumes the link front end fills a command request per finished command.
package vcl_pkg;
  typedef struct packed {
    logic valid;
    logic [7:0] code;
    logic [23:0] addr;
    logic [7:0] data0;
    logic [7:0] data1;
    logic two_bytes;
  } vcl_cmd_t;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } vcl_rsp_t;
  typedef struct packed {
    logic srwd;
    logic [2:0] bp;
  } vcl_stat_t;
endpackage
